// *** src/pbp_pkg.sv ***
// package for the parallel host bus port: register map, fields, reset values
// assumes an axi4-lite register slave with 32-bit data, one word per register
package pbp_pkg;
	// register byte addresses
	localparam logic [7:0] OFS_PORT_CONTROL      = 8'h00;
	localparam logic [7:0] OFS_PORT_CONTROL_HIGH = 8'h04;
	localparam logic [7:0] OFS_PORT_MODE         = 8'h08;
	localparam logic [7:0] OFS_ADDRESS           = 8'h0c;
	localparam logic [7:0] OFS_WRITE_ADDRESS     = 8'h10;
	localparam logic [7:0] OFS_DATA_IN           = 8'h14;
	localparam logic [7:0] OFS_DATA_OUT          = 8'h18;
	localparam logic [7:0] OFS_IDLE_CTRL         = 8'h1c;
	// port_control fields
	localparam int CTL_ON      = 15;
	localparam int CTL_STOP_IN_IDLE    = 13;
	localparam int CTL_MUX_LO  = 11;
	localparam int CTL_WREN    = 9;
	localparam int CTL_RDEN    = 8;
	localparam int CTL_CSF_LO  = 6;
	localparam int CTL_ALP     = 5;
	localparam int CTL_CHIP_SELECT_TWO_POLARITY    = 4;
	localparam int CTL_CHIP_SELECT_ONE_POLARITY    = 3;
	localparam int CTL_WRITE_STROBE_POLARITY    = 1;
	localparam int CTL_READ_STROBE_POLARITY    = 0;
	localparam logic [15:0] CTL_WMASK = 16'hbfff & ~16'h0004;
	// port_control_high fields
	localparam int CTH_LAUNCH  = 7;
	localparam int CTH_SPLIT   = 1;
	// port_mode fields
	localparam int MOD_BUSY    = 15;
	localparam int MOD_IRQ_LO  = 13;
	localparam int MOD_INC_LO  = 11;
	localparam int MOD_WIDE    = 10;
	localparam int MOD_MODE_LO = 8;
	localparam int MOD_SETUP_LO = 6;
	localparam int MOD_STROBE_LO = 2;
	localparam int MOD_HOLD_LO = 0;
	localparam logic [15:0] MOD_WMASK = 16'h7fff;
	// reset values
	localparam logic [15:0] RST_REG16 = 16'h0000;
	// field codes
	localparam logic [1:0] MUX_NONE = 2'h0;
	localparam logic [1:0] MUX_LOW8 = 2'h1;
	localparam logic [1:0] MUX_THREE = 2'h2;
	localparam logic [1:0] MUX_FULL = 2'h3;
	localparam logic [1:0] CSF_BOTH = 2'h2;
	localparam logic [1:0] CSF_TWO  = 2'h1;
	localparam logic [1:0] STEP_INC = 2'h1;
	localparam logic [1:0] STEP_DEC = 2'h2;
	localparam logic [1:0] IRQ_END  = 2'h1;
	localparam logic [1:0] MODE_MASTER_COMB = 2'h3;
	localparam logic [1:0] MODE_MASTER_SEP  = 2'h2;
	localparam logic [1:0] AXI_OKAY   = 2'h0;
	localparam logic [1:0] AXI_DECERR = 2'h3;
	// bus sequencer states
	typedef enum logic [5:0] {
		ST_IDLE  = 6'b000001,
		ST_ADDRH = 6'b000010,
		ST_ADDRL = 6'b000100,
		ST_SETUP = 6'b001000,
		ST_STRB  = 6'b010000,
		ST_HOLD  = 6'b100000
	} seq_state_type;
endpackage

// *** src/parallel_host_bus_port.sv ***
// parallel host bus port: master-mode bus sequencer with axi4-lite registers
// assumes one clock, synchronous active-low reset, pins driven via enables
//
// Operation
// - enable bit clear means no external bus access; set enables the port.
// - stop-in-idle set halts the port while the device idles.
// - mux 11: 16-bit address, then 16-bit data, on shared lines.
// - mux 10: upper address byte, lower byte, then data byte.
// - mux 01 shares low address byte only; mux 00 keeps separate pins.
// - chip-select field picks chip select or address role of top pins.
// - latch polarity sets both latches; each select has own polarity.
// - latch and select polarities ignored where pins are address lines.
// - write polarity sets write strobe, or enable strobe in mode 11.
// - read polarity sets read strobe, or direction strobe in mode 11.
// - strobe pins driven only while their pin enable bits are set.
// - writing one to read launch starts a read; cleared when done.
// - split buffers select separate read and write address and data.
// - busy flag high during a bus cycle, low when idle.
// - interrupt mode 01 pulses interrupt at each cycle end.
// - step mode increments, decrements, or holds address per cycle.
// - top address bits used as chip selects are not stepped.
// - address steps by exactly one regardless of width.
// - wide bit gives one 16-bit transfer, else one 8-bit transfer.
// - mode field picks combined or separate master; other codes leave the port inactive.
// - setup wait gives 1 to 4 clocks; also address phase length.
// - strobe wait zero forces setup one, hold one write, zero read.
// - strobe wait stretches strobe from 1 to 16 clocks.
// - hold wait 1 to 4 clocks on writes, 0 to 3 on reads.
`timescale 1ns/100ps
module parallel_host_bus_port
	import pbp_pkg::*;
#(
	parameter int ADDR_W = 16
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        device_idle,
	output logic [15:0]      bus_address_pins,
	input  wire logic [15:0] bus_data_in,
	output logic [15:0]      bus_data_out,
	output logic [15:0]      bus_data_oe,
	output logic             chip_select_one,
	output logic             chip_select_two,
	output logic             addr_latch_low,
	output logic             addr_latch_high,
	output logic             read_strobe,
	output logic             read_strobe_oe,
	output logic             write_strobe,
	output logic             write_strobe_oe,
	output logic             cycle_done_irq
);
	initial begin
		if (ADDR_W != 16)
			$error("address width must be 16");
	end

	logic [15:0] ctl_q, mod_q, addr_q, waddr_q, din_q, dout_q;
	logic        launch_q, split_q;
	seq_state_type st_q;
	logic [3:0]  cnt_q;
	logic        rd_q;
	logic [15:0] cyc_addr_q, cyc_data_q;
	logic        aw_held_q, w_held_q;
	logic [7:0]  aw_q;
	logic [31:0] wd_q;
	logic [3:0]  ws_q;

	// control field views
	logic [1:0] mux, chip_select_function, mode, step;
	logic       run, wide, master;
	assign mux    = ctl_q[CTL_MUX_LO +: 2];
	assign chip_select_function    = ctl_q[CTL_CSF_LO +: 2];
	assign mode   = mod_q[MOD_MODE_LO +: 2];
	assign step   = mod_q[MOD_INC_LO +: 2];
	assign wide   = mod_q[MOD_WIDE];
	assign master = mode[1];
	assign run    = ctl_q[CTL_ON]
		&& !(ctl_q[CTL_STOP_IN_IDLE] && device_idle);

	// strobe timing from wait fields
	function automatic logic [3:0] setup_len(input logic [15:0] m);
		setup_len = {2'h0, m[MOD_SETUP_LO +: 2]};
		if (m[MOD_STROBE_LO +: 4] == 4'h0)
			setup_len = 4'h0;
	endfunction
	function automatic logic [3:0] hold_len(input logic [15:0] m,
		input logic rd);
		hold_len = {2'h0, m[MOD_HOLD_LO +: 2]};
		if (m[MOD_STROBE_LO +: 4] == 4'h0)
			hold_len = 4'h0;
	endfunction

	// axi handshake: accept address and data in either order
	logic do_wr;
	assign do_wr = aw_held_q && w_held_q && !s_axi_bvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			aw_q      <= 8'h00;
			wd_q      <= 32'h0;
			ws_q      <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= AXI_OKAY;
		end else begin
			s_axi_awready <= !aw_held_q && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_held_q && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				aw_q      <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				wd_q     <= s_axi_wdata;
				ws_q     <= s_axi_wstrb;
			end
			if (do_wr) begin
				aw_held_q    <= 1'b0;
				w_held_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_q[7:2] <= OFS_DATA_OUT[7:2]
					&& aw_q[1:0] == 2'h0) ? AXI_OKAY : AXI_DECERR;
			end else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// byte-lane merge for 16-bit registers
	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] s);
		merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	logic wr_ctl, wr_cth, wr_mod, wr_addr, wr_waddr, wr_din, wr_dout;
	assign wr_ctl   = do_wr && aw_q == OFS_PORT_CONTROL;
	assign wr_cth   = do_wr && aw_q == OFS_PORT_CONTROL_HIGH;
	assign wr_mod   = do_wr && aw_q == OFS_PORT_MODE;
	assign wr_addr  = do_wr && aw_q == OFS_ADDRESS;
	assign wr_waddr = do_wr && aw_q == OFS_WRITE_ADDRESS;
	assign wr_din   = do_wr && aw_q == OFS_DATA_IN;
	assign wr_dout  = do_wr && aw_q == OFS_DATA_OUT;

	// start conditions; a write to the data register starts a bus write
	logic idle, start_rd, start_wr, cyc_end;
	assign idle     = st_q == ST_IDLE;
	assign start_wr = idle && run && master && (split_q ? wr_dout : wr_din)
		&& !launch_q;
	assign start_rd = idle && run && master && launch_q;
	assign cyc_end  = st_q == ST_HOLD && cnt_q == 4'h0 ||
		st_q == ST_STRB && cnt_q == 4'h0 && hold_len(mod_q, rd_q) == 4'h0
		&& rd_q;

	// configuration registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctl_q   <= RST_REG16;
			mod_q   <= RST_REG16;
			split_q <= 1'b0;
		end else begin
			if (wr_ctl)
				ctl_q <= merge(ctl_q, wd_q, ws_q) & CTL_WMASK;
			if (wr_mod)
				mod_q <= merge(mod_q, wd_q, ws_q) & MOD_WMASK;
			if (wr_cth && ws_q[0])
				split_q <= wd_q[CTH_SPLIT];
		end
	end

	// read launch: a written one sets, end of read clears; set wins
	always_ff @(posedge aclk) begin
		if (!aresetn)
			launch_q <= 1'b0;
		else if (wr_cth && ws_q[0] && wd_q[CTH_LAUNCH])
			launch_q <= 1'b1;
		else if (cyc_end && rd_q)
			launch_q <= 1'b0;
	end

	// address stepping keeps chip-select bits out of the count
	function automatic logic [15:0] stepped(input logic [15:0] a,
		input logic [1:0] m, input logic [1:0] cf);
		logic [15:0] n;
		logic [15:0] keep;
		n = a;
		if (m == STEP_INC)
			n = a + 16'h0001;
		else if (m == STEP_DEC)
			n = a - 16'h0001;
		keep = (cf == CSF_BOTH) ? 16'hc000 :
			(cf == CSF_TWO) ? 16'h8000 : 16'h0000;
		stepped = (a & keep) | (n & ~keep);
	endfunction

	// address and data registers; addresses stepped and read data captured at each cycle end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			addr_q  <= RST_REG16;
			waddr_q <= RST_REG16;
			din_q   <= RST_REG16;
			dout_q  <= RST_REG16;
		end else begin
			if (wr_addr)
				addr_q <= merge(addr_q, wd_q, ws_q);
			else if (cyc_end && (rd_q || !split_q))
				addr_q <= stepped(addr_q, step, chip_select_function);
			if (wr_waddr)
				waddr_q <= merge(waddr_q, wd_q, ws_q);
			else if (cyc_end && !rd_q && split_q)
				waddr_q <= stepped(waddr_q, step, chip_select_function);
			if (wr_din)
				din_q <= merge(din_q, wd_q, ws_q);
			else if (cyc_end && rd_q)
				din_q <= wide ? bus_data_in :
					{8'h00, bus_data_in[7:0]};
			if (wr_dout)
				dout_q <= merge(dout_q, wd_q, ws_q);
		end
	end

	// bus sequencer: address phases, setup, strobe, hold
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q       <= ST_IDLE;
			cnt_q      <= 4'h0;
			rd_q       <= 1'b0;
			cyc_addr_q <= 16'h0;
			cyc_data_q <= 16'h0;
		end else begin
			case (st_q)
				ST_IDLE: begin
					if (start_rd || start_wr) begin
						rd_q       <= start_rd;
						cyc_addr_q <= (start_wr && split_q) ? waddr_q : addr_q;
						cyc_data_q <= split_q ? merge(dout_q, wd_q, ws_q)
							: merge(din_q, wd_q, ws_q);
						cnt_q <= {2'h0, mod_q[MOD_SETUP_LO +: 2]};
						if (mux == MUX_THREE)
							st_q <= ST_ADDRH;
						else if (mux != MUX_NONE)
							st_q <= ST_ADDRL;
						else begin
							st_q  <= ST_SETUP;
							cnt_q <= setup_len(mod_q);
						end
					end
				end
				ST_ADDRH: begin
					cnt_q <= cnt_q - 4'h1;
					if (cnt_q == 4'h0) begin
						st_q  <= ST_ADDRL;
						cnt_q <= {2'h0, mod_q[MOD_SETUP_LO +: 2]};
					end
				end
				ST_ADDRL: begin
					cnt_q <= cnt_q - 4'h1;
					if (cnt_q == 4'h0) begin
						st_q  <= ST_SETUP;
						cnt_q <= setup_len(mod_q);
					end
				end
				ST_SETUP: begin
					cnt_q <= cnt_q - 4'h1;
					if (cnt_q == 4'h0) begin
						st_q  <= ST_STRB;
						cnt_q <= mod_q[MOD_STROBE_LO +: 4];
					end
				end
				ST_STRB: begin
					cnt_q <= cnt_q - 4'h1;
					if (cnt_q == 4'h0) begin
						// a read with zero hold ends with the strobe
						st_q  <= cyc_end ? ST_IDLE : ST_HOLD;
						cnt_q <= rd_q ? hold_len(mod_q, 1'b1) - 4'h1
							: hold_len(mod_q, 1'b0);
					end
				end
				ST_HOLD: begin
					cnt_q <= cnt_q - 4'h1;
					if (cnt_q == 4'h0)
						st_q <= ST_IDLE;
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	// pin drive; when muxed, the address phases (high byte, low byte or full word) go out on the data lines before the data phase
	logic [15:0] a_pins, d_pins, d_oe;
	logic        strb, lat_l, lat_h;
	always_comb begin
		a_pins = cyc_addr_q;
		d_pins = rd_q ? 16'h0000 : cyc_data_q;
		d_oe   = (rd_q || idle) ? 16'h0000 : (wide ? 16'hffff : 16'h00ff);
		lat_l  = 1'b0;
		lat_h  = 1'b0;
		if (st_q == ST_ADDRH) begin
			d_pins = {8'h00, cyc_addr_q[15:8]};
			d_oe   = 16'h00ff;
			lat_h  = 1'b1;
		end else if (st_q == ST_ADDRL) begin
			d_pins = (mux == MUX_FULL) ? cyc_addr_q :
				{8'h00, cyc_addr_q[7:0]};
			d_oe   = (mux == MUX_FULL) ? 16'hffff : 16'h00ff;
			lat_l  = 1'b1;
			lat_h  = mux == MUX_FULL;
		end
		if (mux == MUX_LOW8)
			a_pins[7:0] = 8'h00;
		else if (mux == MUX_THREE || mux == MUX_FULL)
			a_pins = 16'h0000;
		if (chip_select_function == CSF_BOTH || chip_select_function == CSF_TWO)
			a_pins[15] = 1'b0;
		if (chip_select_function == CSF_BOTH)
			a_pins[14] = 1'b0;
		strb = st_q == ST_STRB;
	end

	// registered pin outputs with polarity applied
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bus_address_pins <= 16'h0;
			bus_data_out     <= 16'h0;
			bus_data_oe      <= 16'h0;
			chip_select_one  <= 1'b0;
			chip_select_two  <= 1'b0;
			addr_latch_low   <= 1'b0;
			addr_latch_high  <= 1'b0;
			read_strobe      <= 1'b0;
			write_strobe     <= 1'b0;
			read_strobe_oe   <= 1'b0;
			write_strobe_oe  <= 1'b0;
			cycle_done_irq   <= 1'b0;
		end else begin
			bus_address_pins <= a_pins;
			bus_data_out     <= d_pins;
			bus_data_oe      <= d_oe;
			chip_select_two  <= (chip_select_function == CSF_BOTH || chip_select_function == CSF_TWO) ?
				((!idle && cyc_addr_q[15]) ~^ ctl_q[CTL_CHIP_SELECT_TWO_POLARITY])
				: a_pins[15];
			chip_select_one  <= (chip_select_function == CSF_BOTH) ?
				((!idle && cyc_addr_q[14]) ~^ ctl_q[CTL_CHIP_SELECT_ONE_POLARITY])
				: a_pins[14];
			addr_latch_low   <= (mux != MUX_NONE) ?
				(lat_l ~^ ctl_q[CTL_ALP]) : a_pins[0];
			addr_latch_high  <= (mux != MUX_NONE) ?
				(lat_h ~^ ctl_q[CTL_ALP]) : a_pins[1];
			if (mode == MODE_MASTER_COMB) begin
				write_strobe <= strb ~^ ctl_q[CTL_WRITE_STROBE_POLARITY];
				read_strobe  <= (!idle && rd_q) ~^ ctl_q[CTL_READ_STROBE_POLARITY];
			end else begin
				write_strobe <= (strb && !rd_q) ~^ ctl_q[CTL_WRITE_STROBE_POLARITY];
				read_strobe  <= (strb && rd_q) ~^ ctl_q[CTL_READ_STROBE_POLARITY];
			end
			write_strobe_oe <= run && master && ctl_q[CTL_WREN];
			read_strobe_oe  <= run && master && ctl_q[CTL_RDEN];
			cycle_done_irq  <= cyc_end
				&& mod_q[MOD_IRQ_LO +: 2] == IRQ_END;
		end
	end

	// read channel; busy reflects the sequencer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= AXI_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= AXI_OKAY;
				case (s_axi_araddr)
					OFS_PORT_CONTROL:      s_axi_rdata <= {16'h0, ctl_q};
					OFS_PORT_CONTROL_HIGH: s_axi_rdata <= {24'h0, launch_q,
						5'h00, split_q, 1'b0};
					OFS_PORT_MODE: s_axi_rdata <= {16'h0, !idle,
						mod_q[14:0]};
					OFS_ADDRESS:       s_axi_rdata <= {16'h0, addr_q};
					OFS_WRITE_ADDRESS: s_axi_rdata <= {16'h0, waddr_q};
					OFS_DATA_IN:       s_axi_rdata <= {16'h0, din_q};
					OFS_DATA_OUT:      s_axi_rdata <= {16'h0, dout_q};
					default: begin
						s_axi_rdata <= 32'h0;
						s_axi_rresp <= AXI_DECERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
endmodule // parallel_host_bus_port

// *** verification/pbp_asserts.sv ***
// checker for the parallel host bus port: relations seen at the top ports
// assumes one clock, synchronous active-low reset, bound into the design
`timescale 1ns/100ps
module pbp_asserts
	import pbp_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        device_idle,
	input wire logic        read_strobe,
	input wire logic        read_strobe_oe,
	input wire logic        write_strobe,
	input wire logic        write_strobe_oe,
	input wire logic        addr_latch_low,
	input wire logic        addr_latch_high,
	input wire logic        cycle_done_irq
);
	logic [7:0]  wa_q;
	logic [15:0] wd_q;
	logic [15:0] ctl_q;
	logic [15:0] mode_q;
	logic [1:0]  cnt_q;
	logic        quiet;
	logic        w_hs;
	logic        go;
	// shadows lag the design, so checks wait until writes have settled
	assign quiet = (cnt_q == 2'h3);
	assign w_hs = s_axi_wvalid && s_axi_wready;
	assign go = ctl_q[CTL_ON] && mode_q[MOD_MODE_LO+1]
		&& (mode_q[MOD_IRQ_LO+:2] == IRQ_END)
		&& !(ctl_q[CTL_STOP_IN_IDLE] && device_idle);

	// capture the write address and data as each channel is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wa_q <= 8'h00;
			wd_q <= 16'h0000;
		end else begin
			if (s_axi_awvalid && s_axi_awready) wa_q <= s_axi_awaddr;
			if (w_hs) wd_q <= s_axi_wdata[15:0];
		end
	end

	// register shadows, committed at the write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctl_q <= 16'h0000;
			mode_q <= 16'h0000;
		end else if (s_axi_bvalid && s_axi_bready) begin
			if (wa_q == OFS_PORT_CONTROL) ctl_q <= wd_q & CTL_WMASK;
			if (wa_q == OFS_PORT_MODE) mode_q <= wd_q;
		end
	end

	// settle counter, restarted by a write address or a pending write response
	always_ff @(posedge aclk) begin
		if (!aresetn || s_axi_awvalid || s_axi_bvalid) cnt_q <= 2'h0;
		else if (cnt_q != 2'h3) cnt_q <= cnt_q + 2'h1;
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_irq_pulse;
		cycle_done_irq |=> !cycle_done_irq;
	endproperty
	a_irq_pulse: assert property (p_irq_pulse)
		else $error("cycle end pulse longer than one cycle");
	property p_irq_none;
		quiet && (mode_q[MOD_IRQ_LO+:2] != IRQ_END) |-> !cycle_done_irq;
	endproperty
	a_irq_none: assert property (p_irq_none)
		else $error("cycle end pulse while interrupt mode is not 01");
	property p_wr_oe;
		quiet && !ctl_q[CTL_WREN] |-> !write_strobe_oe;
	endproperty
	a_wr_oe: assert property (p_wr_oe)
		else $error("write strobe driven while its pin is disabled");
	property p_rd_oe;
		quiet && !ctl_q[CTL_RDEN] |-> !read_strobe_oe;
	endproperty
	a_rd_oe: assert property (p_rd_oe)
		else $error("read strobe driven while its pin is disabled");
	property p_off;
		quiet && !ctl_q[CTL_ON] |=> $stable({write_strobe, read_strobe,
			addr_latch_low, addr_latch_high});
	endproperty
	a_off: assert property (p_off)
		else $error("bus strobes moved while the port is off");
	property p_stop_in_idle;
		quiet && ctl_q[CTL_STOP_IN_IDLE] && ctl_q[CTL_ON] && device_idle
			|=> $stable({write_strobe, read_strobe, addr_latch_low});
	endproperty
	a_stop_in_idle: assert property (p_stop_in_idle)
		else $error("bus strobes moved while halted in idle");
	property p_launch;
		w_hs && (s_axi_awaddr == OFS_PORT_CONTROL_HIGH)
			&& s_axi_wdata[CTH_LAUNCH] && go |-> ##[1:80] cycle_done_irq;
	endproperty
	a_launch: assert property (p_launch)
		else $error("read launch did not complete a bus cycle");
	property p_wstart;
		w_hs && (s_axi_awaddr == OFS_DATA_IN) && go
			|-> ##[1:80] cycle_done_irq;
	endproperty
	a_wstart: assert property (p_wstart)
		else $error("data write did not complete a bus cycle");

	c_irq: cover property (cycle_done_irq);
	c_oe: cover property ($rose(write_strobe_oe));
	c_idle: cover property (device_idle && ctl_q[CTL_STOP_IN_IDLE]);
endmodule // pbp_asserts

bind parallel_host_bus_port pbp_asserts i_pbp_asserts (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .device_idle(device_idle),
	.read_strobe(read_strobe), .read_strobe_oe(read_strobe_oe),
	.write_strobe(write_strobe), .write_strobe_oe(write_strobe_oe),
	.addr_latch_low(addr_latch_low), .addr_latch_high(addr_latch_high),
	.cycle_done_irq(cycle_done_irq)
);

// *** verification/pbp_far_end.sv ***
// external parallel device model: records writes, answers reads
// assumes the bench tells it the active level of strobes and latches
`timescale 1ns/100ps
module pbp_far_end #(
	parameter logic [15:0] RD_PAT = 16'h6c39
) (
	input  wire logic        aclk,
	input  wire logic        hi,
	input  wire logic [15:0] bus_address_pins,
	input  wire logic [15:0] bus_data_out,
	input  wire logic        write_strobe,
	input  wire logic        write_strobe_oe,
	input  wire logic        read_strobe,
	input  wire logic        read_strobe_oe,
	input  wire logic        addr_latch_low,
	output logic [15:0]      bus_data_in,
	output logic [15:0]      got_addr,
	output logic [15:0]      got_data,
	output logic [15:0]      got_lat,
	output int               got_wid = 0,
	output int               got_cnt = 0
);
	int          run_q = 0;
	logic        rd_q = 1'b0;
	logic [15:0] alt_q = 16'h0000;
	logic        wr_act;
	logic        rd_act;
	// a strobe counts only while the port drives it at its active level
	assign wr_act = write_strobe_oe && (write_strobe === hi);
	assign rd_act = read_strobe_oe && (read_strobe === hi);
	// released lines toggle each cycle so a late sample never matches
	assign bus_data_in = (rd_act || rd_q) ? RD_PAT : alt_q;

	// record latched address, strobe width, address and data of writes
	always @(posedge aclk) begin
		alt_q <= ~alt_q;
		rd_q <= rd_act;
		if (addr_latch_low === hi) got_lat <= bus_data_out;
		if (wr_act) begin
			run_q <= run_q + 1;
			got_addr <= bus_address_pins;
			got_data <= bus_data_out;
		end else if (run_q != 0) begin
			got_wid <= run_q;
			got_cnt <= got_cnt + 1;
			run_q <= 0;
		end
	end
endmodule // pbp_far_end

// *** verification/parallel_host_bus_port_test.sv ***
// bench for the parallel host bus port: register bus, bus cycles, faults
// assumes the device model on the far side and the bound checker
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
	$display("mismatch at %0t got %h expected %h", $time, g, e); end end
module parallel_host_bus_port_test;
	import pbp_pkg::*;
	typedef struct {
		logic [15:0] ctl, mode, dat, adr, lat;
		int          wid;
		logic        hi;
	} row_type;
	localparam logic [15:0] RD_PAT = 16'h6c39;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h00000000;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0, device_idle = 1'b0, hi = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp_q;
	logic [31:0] s_axi_rdata;
	logic [15:0] bus_address_pins, bus_data_in, bus_data_out, bus_data_oe;
	logic [15:0] got_addr, got_data, got_lat, m, v;
	logic        chip_select_one, chip_select_two;
	logic        addr_latch_low, addr_latch_high, cycle_done_irq;
	logic        read_strobe, read_strobe_oe, write_strobe, write_strobe_oe;
	int          got_wid, got_cnt, n;
	int          error_cnt = 0;
	int          checks_done = 0;
	// ctl, mode, data, address on the bus, latch mask, strobe width, level
	row_type rows [5] = '{
		'{16'h8300, 16'h2e0c, 16'ha5c3, 16'h01a7, 16'h0000, 4, 1'b0},
		'{16'h8323, 16'h3200, 16'h125a, 16'h01a8, 16'h0000, 1, 1'b1},
		'{16'h8b00, 16'h26fc, 16'h3c96, 16'h01a7, 16'h00ff, 16, 1'b0},
		'{16'h9b23, 16'h2f07, 16'h0ff0, 16'h01a7, 16'hffff, 2, 1'b1},
		'{16'h9300, 16'h2208, 16'h00e7, 16'h01a8, 16'h00ff, 3, 1'b0}};

	parallel_host_bus_port i_parallel_host_bus_port (.aclk, .aresetn,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .device_idle, .bus_address_pins, .bus_data_in,
		.bus_data_out, .bus_data_oe, .chip_select_one, .chip_select_two,
		.addr_latch_low, .addr_latch_high, .read_strobe, .read_strobe_oe,
		.write_strobe, .write_strobe_oe, .cycle_done_irq);
	pbp_far_end #(.RD_PAT(RD_PAT)) i_pbp_far_end (.aclk, .hi,
		.bus_address_pins, .bus_data_out, .write_strobe, .write_strobe_oe,
		.read_strobe, .read_strobe_oe, .addr_latch_low, .bus_data_in,
		.got_addr, .got_data, .got_lat, .got_wid, .got_cnt);

	// 250 mhz clock
	initial begin
		forever #2 aclk = ~aclk;
	end

	task automatic end_of_test;
		if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// one register write; address and data offered together
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		resp_q = s_axi_bresp;
	endtask

	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata[15:0];
		resp_q = s_axi_rresp;
	endtask

	// bounded by the watchdog, which ends a hang
	task automatic wait_irq;
		do @(posedge aclk); while (cycle_done_irq !== 1'b1);
		@(posedge aclk);
	endtask

	// a full run needs under a thousand cycles; allow far more
	initial begin
		#80000;
		error_cnt++;
		end_of_test();
	end

	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rd(OFS_PORT_CONTROL, v); `CHK(v, RST_REG16)
		rd(OFS_PORT_CONTROL_HIGH, v); `CHK(v, RST_REG16)
		rd(OFS_PORT_MODE, v); `CHK(v, RST_REG16)
		rd(8'h40, v); `CHK(resp_q, AXI_DECERR)
		wr(8'h40, 16'h1234); `CHK(resp_q, AXI_DECERR)
		// reserved bits and the busy flag ignore writes
		wr(OFS_PORT_CONTROL, 16'hffff);
		rd(OFS_PORT_CONTROL, v); `CHK(v, CTL_WMASK)
		wr(OFS_PORT_MODE, 16'hffff);
		rd(OFS_PORT_MODE, v); `CHK(v, MOD_WMASK)
		wr(OFS_PORT_CONTROL, 16'h0000);
		wr(OFS_PORT_MODE, 16'h0000);
		wr(OFS_ADDRESS, 16'h01a7);
		// one bus write per row, address stepping carried across rows
		foreach (rows[i]) begin
			wr(OFS_PORT_MODE, rows[i].mode);
			wr(OFS_PORT_CONTROL, rows[i].ctl);
			hi <= rows[i].hi;
			wr(OFS_DATA_IN, rows[i].dat);
			wait_irq();
			m = rows[i].mode[MOD_WIDE] ? 16'hffff : 16'h00ff;
			`CHK(got_wid, rows[i].wid)
			`CHK(got_data & m, rows[i].dat & m)
			`CHK(got_lat & rows[i].lat, rows[i].adr & rows[i].lat)
			if (rows[i].lat == 16'h0000) `CHK(got_addr, rows[i].adr)
		end
		// top bits used as chip selects stay out of the increment
		wr(OFS_PORT_MODE, 16'h2a00);
		wr(OFS_PORT_CONTROL, 16'h8380);
		wr(OFS_ADDRESS, 16'hbfff);
		wr(OFS_DATA_IN, 16'h0055);
		wait_irq();
		rd(OFS_ADDRESS, v); `CHK(v, 16'h8000)
		// read launch: bit clears when done, data lands in the data register
		wr(OFS_PORT_CONTROL, 16'h8300);
		wr(OFS_PORT_MODE, 16'h260c);
		wr(OFS_PORT_CONTROL_HIGH, 16'h0080);
		do rd(OFS_PORT_CONTROL_HIGH, v); while (v[CTH_LAUNCH] !== 1'b0);
		rd(OFS_DATA_IN, v); `CHK(v, RD_PAT)
		// port off: a data write must not reach the bus
		wr(OFS_PORT_CONTROL, 16'h0300);
		n = got_cnt;
		wr(OFS_DATA_IN, 16'h0f0f);
		repeat (40) @(posedge aclk);
		`CHK(got_cnt, n)
		// halted while the device idles
		wr(OFS_PORT_CONTROL, 16'ha300);
		device_idle <= 1'b1;
		n = got_cnt;
		wr(OFS_DATA_IN, 16'hf0f0);
		repeat (40) @(posedge aclk);
		`CHK(got_cnt, n)
		device_idle <= 1'b0;
		end_of_test();
	end
endmodule // parallel_host_bus_port_test
